// [cipher_pkg.sv]
// Purpose: Shared constants for the dual block cipher engine.
// Assumes: APB word access, 32-bit data.
// Notes:   Offsets are byte addresses inside a 256-byte engine window.
package cipher_pkg;
    localparam logic [7:0]  OFS_CTRL  = 8'h00;
    localparam logic [7:0]  OFS_STAT  = 8'h04;
    localparam logic [7:0]  OFS_DIN   = 8'h08;
    localparam logic [7:0]  OFS_DOUT  = 8'h0C;
    localparam logic [7:0]  OFS_KEY   = 8'h10;
    localparam logic [7:0]  OFS_IV    = 8'h30;
    localparam logic [7:0]  OFS_LAST  = 8'h3C;
    localparam logic [7:0]  OFS_BKEY  = 8'h00;
    localparam logic [7:0]  OFS_BSTAT = 8'h20;
    localparam logic [3:0]  WIN_HARD  = 4'h0;
    localparam logic [3:0]  WIN_FAST  = 4'h1;
    localparam logic [3:0]  WIN_BOOT  = 4'h2;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam int CB_EN    = 0;
    localparam int CB_MODE  = 1;
    localparam int CB_DEC   = 4;
    localparam int CB_K256  = 5;
    localparam int CB_SWAP  = 6;
    localparam int CB_SRC   = 8;
    localparam int CB_IDMA  = 10;
    localparam int CB_ODMA  = 11;
    localparam int CB_SEC   = 12;
    localparam int CB_WRAP  = 13;
    localparam int CB_SHARE = 14;
    localparam logic [9:0] LAT_HARD_128 = 10'd528;
    localparam logic [9:0] LAT_HARD_256 = 10'd743;
    localparam logic [9:0] LAT_FAST_128 = 10'd51;
    localparam logic [9:0] LAT_FAST_256 = 10'd75;
    localparam logic [9:0] LAT_PREP     = 10'd16;
    typedef enum logic [2:0] {M_ECB, M_CBC, M_CTR, M_GCM, M_GMAC, M_CCM} mode_t;
    typedef enum logic [1:0] {K_SOFT, K_DERIVED, K_BOOT, K_XOR} key_src_t;
    typedef enum logic [1:0] {SW_32, SW_16, SW_8, SW_1} swap_t;

    function automatic logic [31:0] swap_word(input logic [31:0] w, input logic [1:0] sel);
        logic [31:0] r;
        r = w;
        unique case (swap_t'(sel))
            SW_32: r = w;
            SW_16: r = {w[15:0], w[31:16]};
            SW_8:  r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            SW_1:  for (int i = 0; i < 32; i++) r[i] = w[31-i];
        endcase
        return r;
    endfunction : swap_word
endpackage : cipher_pkg

// [block_cipher_dual_engine.sv]
// Purpose: Hardened and fast block cipher engines behind one APB slave.
// Assumes: Single clock pclk at 250 MHz, asynchronous active-low presetn.
// Notes:   The round datapath is a stand-in with the true latencies, masked in the hardened engine only.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cipher_engine
    import cipher_pkg::*;
#(
    parameter bit HARD = 1'b1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    output logic      [31:0]  reg_rdata,
    input  wire logic [255:0] key_share_in,
    output logic      [255:0] key_share_out,
    input  wire logic [255:0] derived_key_s,
    input  wire logic [255:0] derived_key_ns,
    input  wire logic [255:0] boot_key,
    input  wire logic         boot_key_ok,
    input  wire logic         breach,
    input  wire logic [31:0]  rng_word,
    output logic              dma_in_req,
    output logic              dma_out_req,
    output logic              busy
);
    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_PREP, S_RUN, S_OUT} state_t;

    state_t         state_r;
    logic [31:0]    ctrl_r;
    logic [255:0]   key_r;
    logic [7:0]     kmask_r;
    logic [127:0]   iv_r;
    logic [127:0]   blk_r;
    logic [127:0]   res_r;
    logic [127:0]   s_r;
    logic [127:0]   m_r;
    logic [1:0]     wcnt_r;
    logic [1:0]     rcnt_r;
    logic [9:0]     cnt_r;
    logic           wrap_hi_r;
    mode_t          mode;
    logic           dec;
    logic           k256;
    logic [255:0]   sel_key;
    logic [127:0]   kx;
    logic           key_ok;
    logic [9:0]     lat;
    logic           need_prep;
    logic           go_run;
    logic           fin;
    logic           din_wr;
    logic           dout_rd;
    logic [127:0]   cin;
    logic [127:0]   cout;
    logic [127:0]   out_blk;
    logic [127:0]   iv_nxt;
    logic [127:0]   mask0;

    assign mode      = mode_t'(ctrl_r[CB_MODE+:3]);
    assign dec       = ctrl_r[CB_DEC];
    assign k256      = ctrl_r[CB_K256];
    assign din_wr    = reg_wr && reg_addr == OFS_DIN && state_r == S_IDLE;
    assign dout_rd   = reg_rd && reg_addr == OFS_DOUT && state_r == S_OUT;
    assign fin       = state_r == S_RUN && cnt_r == 10'h000;
    assign need_prep = dec && (mode == M_ECB || mode == M_CBC);
    assign go_run    = (state_r == S_WAIT && key_ok && !need_prep) ||
                       (state_r == S_PREP && cnt_r == 10'h000);
    assign mask0     = HARD ? {4{rng_word}} : 128'h0;

    always_comb begin
        unique case ({HARD, k256})
            2'b11:   lat = LAT_HARD_256;
            2'b10:   lat = LAT_HARD_128;
            2'b01:   lat = LAT_FAST_256;
            default: lat = LAT_FAST_128;
        endcase
    end

    // Hardware key sources are only selectable in the hardened engine; the fast engine can take its selected key by the share copy.
    always_comb begin
        logic [255:0] dk;
        dk = ctrl_r[CB_SEC] ? derived_key_s : derived_key_ns;
        unique case (key_src_t'(ctrl_r[CB_SRC+:2]))
            K_SOFT:    sel_key = key_r;
            K_DERIVED: sel_key = dk;
            K_BOOT:    sel_key = boot_key;
            K_XOR:     sel_key = dk ^ boot_key;
        endcase
        if (key_src_t'(ctrl_r[CB_SRC+:2]) == K_SOFT) begin
            key_ok = kmask_r == 8'hFF || (!k256 && kmask_r[3:0] == 4'hF);
        end else begin
            key_ok = HARD && !breach &&
                     (key_src_t'(ctrl_r[CB_SRC+:2]) == K_DERIVED || boot_key_ok);
        end
    end

    assign kx            = k256 ? sel_key[127:0] ^ sel_key[255:128] : sel_key[127:0];
    assign key_share_out = sel_key;

    // Chaining around the core; the counter modes feed the IV through it.
    always_comb begin
        unique case (mode)
            M_ECB:   cin = blk_r;
            M_CBC:   cin = dec ? blk_r : blk_r ^ iv_r;
            default: cin = iv_r;
        endcase
        cout = s_r ^ m_r ^ kx;
        unique case (mode)
            M_ECB: begin
                out_blk = cout;
                iv_nxt  = iv_r;
            end
            M_CBC: begin
                out_blk = dec ? cout ^ iv_r : cout;
                iv_nxt  = dec ? blk_r : cout;
            end
            default: begin
                out_blk = blk_r ^ cout;
                iv_nxt  = iv_r + 128'h1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
        end else if (reg_wr && reg_addr == OFS_CTRL) begin
            // The share bit is a command and never stays set.
            ctrl_r <= {reg_wdata[31:15], 1'b0, HARD & reg_wdata[CB_WRAP],
                       reg_wdata[12:10], HARD ? reg_wdata[9:8] : 2'h0, reg_wdata[7:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_r     <= 256'h0;
            kmask_r   <= 8'h00;
            wrap_hi_r <= 1'b0;
        end else if (fin && ctrl_r[CB_WRAP]) begin
            key_r[128*wrap_hi_r+:128]  <= out_blk;
            kmask_r[4*wrap_hi_r+:4]    <= 4'hF;
            wrap_hi_r                  <= !wrap_hi_r;
        end else if (!HARD && reg_wr && reg_addr == OFS_CTRL &&
                     reg_wdata[CB_SHARE] && state_r == S_IDLE) begin
            key_r   <= key_share_in;
            kmask_r <= 8'hFF;
        end else if (reg_wr && reg_addr >= OFS_KEY && reg_addr < OFS_IV &&
                     state_r == S_IDLE) begin
            key_r[32*(reg_addr[4:2] ^ 3'h4)+:32] <= reg_wdata;
            kmask_r[reg_addr[4:2] ^ 3'h4]       <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iv_r <= 128'h0;
        end else if (fin) begin
            iv_r <= iv_nxt;
        end else if (reg_wr && reg_addr[7:4] == OFS_IV[7:4] && state_r == S_IDLE) begin
            // Restoring the IV is how a suspended message resumes.
            iv_r[32*reg_addr[3:2]+:32] <= reg_wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            wcnt_r  <= 2'h0;
            rcnt_r  <= 2'h0;
            cnt_r   <= 10'h000;
            blk_r   <= 128'h0;
            res_r   <= 128'h0;
            s_r     <= 128'h0;
            m_r     <= 128'h0;
        end else if (!ctrl_r[CB_EN]) begin
            // Disabling drops a partial block, so suspend only between blocks.
            state_r <= S_IDLE;
            wcnt_r  <= 2'h0;
            rcnt_r  <= 2'h0;
        end else begin
            if (go_run) begin
                state_r <= S_RUN;
                cnt_r   <= lat - 10'h001;
                s_r     <= cin ^ mask0;
                m_r     <= mask0;
            end
            unique case (state_r)
                S_IDLE: if (din_wr) begin
                    blk_r[32*wcnt_r+:32] <= swap_word(reg_wdata, ctrl_r[CB_SWAP+:2]);
                    wcnt_r               <= wcnt_r + 2'h1;
                    if (wcnt_r == 2'h3) begin
                        state_r <= S_WAIT;
                    end
                end
                S_WAIT: if (key_ok && need_prep) begin
                    state_r <= S_PREP;
                    cnt_r   <= LAT_PREP - 10'h001;
                end
                S_PREP: if (cnt_r != 10'h000) begin
                    cnt_r <= cnt_r - 10'h001;
                end
                S_RUN: begin
                    s_r <= s_r ^ mask0;
                    m_r <= m_r ^ mask0;
                    if (cnt_r != 10'h000) begin
                        cnt_r <= cnt_r - 10'h001;
                    end else if (ctrl_r[CB_WRAP]) begin
                        state_r <= S_IDLE;
                    end else begin
                        res_r   <= out_blk;
                        rcnt_r  <= 2'h0;
                        state_r <= S_OUT;
                    end
                end
                S_OUT: if (dout_rd) begin
                    rcnt_r <= rcnt_r + 2'h1;
                    if (rcnt_r == 2'h3) begin
                        state_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy        = state_r == S_WAIT || state_r == S_PREP || state_r == S_RUN;
    assign dma_in_req  = ctrl_r[CB_EN] && ctrl_r[CB_IDMA] && state_r == S_IDLE;
    assign dma_out_req = ctrl_r[CB_EN] && ctrl_r[CB_ODMA] && state_r == S_OUT;

    // Key words and hardware keys have no read path at all.
    always_comb begin
        reg_rdata = 32'h0;
        if (reg_addr == OFS_CTRL) begin
            reg_rdata = ctrl_r;
        end else if (reg_addr == OFS_STAT) begin
            reg_rdata = {27'h0, wrap_hi_r, state_r == S_IDLE, state_r == S_OUT,
                         key_ok, busy};
        end else if (reg_addr == OFS_DOUT) begin
            reg_rdata = swap_word(res_r[32*rcnt_r+:32], ctrl_r[CB_SWAP+:2]);
        end else if (reg_addr[7:4] == OFS_IV[7:4]) begin
            reg_rdata = iv_r[32*reg_addr[3:2]+:32];
        end
    end
endmodule : cipher_engine

module block_cipher_dual_engine
    import cipher_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [255:0] derived_unique_key_s,
    input  wire logic [255:0] derived_unique_key_ns,
    input  wire logic [31:0]  rng_word,
    input  wire logic         tamper_event,
    input  wire logic         readout_protection_level_regress,
    input  wire logic         breach_detected,
    output logic              hard_dma_in_req,
    output logic              hard_dma_out_req,
    output logic              fast_dma_in_req,
    output logic              fast_dma_out_req,
    output logic              hard_busy,
    output logic              fast_busy
);
    logic           acc;
    logic           hit_h;
    logic           hit_f;
    logic           hit_b;
    logic           map_ok;
    logic [31:0]    rd_h;
    logic [31:0]    rd_f;
    logic [255:0]   share_key;
    logic [255:0]   boot_secret_key_r;
    logic [7:0]     boot_mask_r;
    logic           boot_lock_r;
    logic           breach_r;
    logic [31:0]    prdata_r;

    assign acc    = psel && penable;
    assign hit_h  = paddr[11:8] == WIN_HARD && paddr[7:0] <= OFS_LAST;
    assign hit_f  = paddr[11:8] == WIN_FAST && paddr[7:0] <= OFS_LAST;
    assign hit_b  = paddr[11:8] == WIN_BOOT && paddr[7:0] <= OFS_BSTAT;
    assign map_ok = (hit_h || hit_f || hit_b) && paddr[1:0] == 2'h0;

    cipher_engine #(.HARD(1'b1)) u_hard (
        .pclk           (pclk),
        .presetn        (presetn),
        .reg_wr         (acc && pwrite && hit_h && map_ok),
        .reg_rd         (acc && !pwrite && hit_h && map_ok),
        .reg_addr       (paddr[7:0]),
        .reg_wdata      (pwdata),
        .reg_rdata      (rd_h),
        .key_share_in   (256'h0),
        .key_share_out  (share_key),
        .derived_key_s  (derived_unique_key_s),
        .derived_key_ns (derived_unique_key_ns),
        .boot_key       (boot_secret_key_r),
        .boot_key_ok    (boot_mask_r == 8'hFF),
        .breach         (breach_r),
        .rng_word       (rng_word),
        .dma_in_req     (hard_dma_in_req),
        .dma_out_req    (hard_dma_out_req),
        .busy           (hard_busy)
    );

    cipher_engine #(.HARD(1'b0)) u_fast (
        .pclk           (pclk),
        .presetn        (presetn),
        .reg_wr         (acc && pwrite && hit_f && map_ok),
        .reg_rd         (acc && !pwrite && hit_f && map_ok),
        .reg_addr       (paddr[7:0]),
        .reg_wdata      (pwdata),
        .reg_rdata      (rd_f),
        .key_share_in   (share_key),
        .key_share_out  (),
        .derived_key_s  (256'h0),
        .derived_key_ns (256'h0),
        .boot_key       (256'h0),
        .boot_key_ok    (1'b0),
        .breach         (breach_r),
        .rng_word       (32'h0),
        .dma_in_req     (fast_dma_in_req),
        .dma_out_req    (fast_dma_out_req),
        .busy           (fast_busy)
    );

    // Clearing beats a write so a tamper can never be outrun by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_secret_key_r <= 256'h0;
            boot_mask_r       <= 8'h00;
            boot_lock_r       <= 1'b0;
        end else begin
            if (tamper_event || readout_protection_level_regress) begin
                boot_secret_key_r <= 256'h0;
                boot_mask_r       <= 8'h00;
            end else if (acc && pwrite && hit_b && map_ok && !boot_lock_r &&
                         paddr[7:5] == OFS_BKEY[7:5]) begin
                boot_secret_key_r[32*paddr[4:2]+:32] <= pwdata;
                boot_mask_r[paddr[4:2]]              <= 1'b1;
            end
            if (boot_mask_r == 8'hFF) begin
                boot_lock_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            breach_r <= 1'b0;
        end else if (breach_detected || tamper_event) begin
            breach_r <= 1'b1;
        end
    end

    // Read data is caught in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (psel && !penable) begin
            if (!map_ok) begin
                prdata_r <= 32'h0;
            end else if (hit_h) begin
                prdata_r <= rd_h;
            end else if (hit_f) begin
                prdata_r <= rd_f;
            end else if (paddr[7:0] == OFS_BSTAT) begin
                prdata_r <= {29'h0, breach_r, boot_mask_r == 8'hFF, boot_lock_r};
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = acc && !map_ok;
endmodule : block_cipher_dual_engine

`default_nettype wire

// [key_source_model.sv]
// Purpose: Hardware key and entropy sources facing the hardened engine.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   The entropy word changes every cycle, so stale use shows up.
`timescale 1ns/1ps
`default_nettype none
module key_source_model (
    input  wire logic         pclk,
    input  wire logic         presetn,
    output logic      [255:0] dk_s,
    output logic      [255:0] dk_ns,
    output logic      [31:0]  rng
);
    // Both key values are arbitrary but differ, so a wrong variant changes the result.
    assign dk_s  = {8{32'h5A3C_9617}};
    assign dk_ns = {8{32'hC3A5_0F1E}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rng <= 32'h0000_0001;
        else
            rng <= {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
    end
endmodule : key_source_model
`default_nettype wire

// [block_cipher_dual_engine_sva.sv]
// Purpose: Port checker for the dual cipher engine.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Latency bounds are the bare core latencies and do not count the one wait cycle before a run.
`timescale 1ns/1ps
`default_nettype none
module cipher_port_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        hard_dma_in_req,
    input wire logic        hard_dma_out_req,
    input wire logic        fast_dma_in_req,
    input wire logic        fast_dma_out_req,
    input wire logic        hard_busy,
    input wire logic        fast_busy
);
    logic [9:0] fcnt_r;
    logic [9:0] hcnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fcnt_r <= 10'h0;
        else
            fcnt_r <= fast_busy ? fcnt_r + 10'h1 : 10'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hcnt_r <= 10'h0;
        else
            hcnt_r <= hard_busy ? hcnt_r + 10'h1 : 10'h0;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_secret_rd;
        psel && !penable && !pwrite && ((paddr[11:8] == 4'h2 && paddr[7:0] < 8'h20)
            || (paddr[11:8] < 4'h2 && paddr[7:4] inside {4'h1, 4'h2}));
    endsequence
    AST_KEY_HIDDEN: assert property (s_secret_rd |=> prdata == 32'h0)
        else $error("secret word readable");
    AST_FAST_IN_IDLE: assert property (fast_dma_in_req |-> !fast_busy)
        else $error("fast input request while busy");
    AST_HARD_IN_IDLE: assert property (hard_dma_in_req |-> !hard_busy)
        else $error("hard input request while busy");
    AST_FAST_OUT: assert property (fast_dma_out_req |-> !fast_busy && !fast_dma_in_req)
        else $error("fast request channels overlap");
    AST_HARD_OUT: assert property (hard_dma_out_req |-> !hard_busy && !hard_dma_in_req)
        else $error("hard request channels overlap");
    AST_FAST_LAT: assert property ($fell(fast_busy) |-> fcnt_r >= 10'd51)
        else $error("fast block too short");
    AST_HARD_LAT: assert property ($fell(hard_busy) |-> hcnt_r >= 10'd528)
        else $error("hard block too short");
    AST_FAST_START: assert property ($rose(fast_busy) |->
        $past(psel && penable && pwrite && paddr == 12'h108))
        else $error("fast block started without input word");
endmodule : cipher_port_chk
bind block_cipher_dual_engine cipher_port_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .hard_dma_in_req(hard_dma_in_req), .hard_dma_out_req(hard_dma_out_req),
    .fast_dma_in_req(fast_dma_in_req), .fast_dma_out_req(fast_dma_out_req),
    .hard_busy(hard_busy), .fast_busy(fast_busy));
`default_nettype wire

// [block_cipher_dual_engine_tb_top.sv]
// Purpose: Self-checking bench for the dual cipher engine.
// Assumes: Zero-wait APB slave, one block per four input words.
// Notes:   The cipher core is a stand-in, so results are checked by timing and flow.
`timescale 1ns/1ps
`default_nettype none
module block_cipher_dual_engine_tb_top
    import cipher_pkg::*;
;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic         tamper = 0, regress = 0, breach = 0, pready, pslverr, e;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, q, n, lfsr_r = 32'h2E7BC053;
    logic [255:0] dk_s, dk_ns;
    logic [31:0]  rng;
    logic         hin, hout, fin, fout, hb, fb;
    int           num_errors = 0, n_compared = 0, cyc = 0;
    always #2 pclk = ~pclk;
    key_source_model u_src (.pclk(pclk), .presetn(presetn), .dk_s(dk_s), .dk_ns(dk_ns),
        .rng(rng));
    block_cipher_dual_engine DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .derived_unique_key_s(dk_s),
        .derived_unique_key_ns(dk_ns), .rng_word(rng), .tamper_event(tamper),
        .readout_protection_level_regress(regress), .breach_detected(breach),
        .hard_dma_in_req(hin), .hard_dma_out_req(hout), .fast_dma_in_req(fin),
        .fast_dma_out_req(fout), .hard_busy(hb), .fast_busy(fb));
    function automatic logic [31:0] nxt();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction : nxt
    function automatic logic [31:0] exp_lat(input bit h, input bit k, input bit p);
        return 32'(h ? (k ? LAT_HARD_256 : LAT_HARD_128) : (k ? LAT_FAST_256 : LAT_FAST_128)) + 1
            + (p ? 32'(LAT_PREP) : 32'h0);
    endfunction : exp_lat
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // The request is held until pready is seen high, whatever the slave's speed.
    task automatic xfer(input int w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w != 0;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic run_block(input bit h, input bit k, input logic [2:0] m, input bit d);
        logic [11:0] b;
        b = h ? 12'h000 : 12'h100;
        for (int i = 0; i < 8; i++) xfer(1, b + OFS_KEY + 12'(4 * i), nxt());
        xfer(1, b + OFS_CTRL, 32'h1 | 32'h0C00 | (32'(k) << CB_K256) | (32'(m) << CB_MODE)
            | (32'(d) << CB_DEC));
        #1 chk(32'(h ? hin : fin), 32'h1);
        for (int i = 0; i < 4; i++) xfer(1, b + OFS_DIN, nxt());
        n = 0;
        @(posedge pclk);
        while ((h ? hb : fb) === 1'b1 && n < 2000) begin
            n++;
            @(posedge pclk);
        end
        chk(n, exp_lat(h, k, d && m < 3'h2));
        #1 chk(32'(h ? hout : fout), 32'h1);
        for (int i = 0; i < 4; i++) xfer(0, b + OFS_DOUT, 0);
        #1 chk(32'({h ? hin : fin, h ? hout : fout}), 32'h2);
        xfer(1, b + OFS_CTRL, CTRL_RST);
    endtask : run_block
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            for (int i = 0; i < 4; i++) begin
                n = nxt();
                xfer(1, 12'(g * 256) + OFS_IV + 12'(4 * i), n);
                xfer(0, 12'(g * 256) + OFS_IV + 12'(4 * i), 0);
                chk(q, n);
                xfer(1, 12'(g * 256) + OFS_KEY + 12'(4 * i), n);
                xfer(0, 12'(g * 256) + OFS_KEY + 12'(4 * i), 0);
                chk(q, 32'h0);
            end
        end
        xfer(0, 12'h3F0, 0);
        chk(32'(e), 32'h1);
        for (int k = 0; k < 10; k++) begin
            run_block(k < 4 && k[1], k < 4 && k[0], k < 4 ? 3'h0 : 3'(k - 4),
                      k inside {4, 5, 6});
        end
        for (int i = 0; i < 8; i++) xfer(1, 12'h200 + 12'(4 * i), nxt());
        xfer(0, 12'h220, 0);
        chk(q & 32'h3, 32'h3);
        xfer(1, 12'h200, nxt());
        xfer(0, 12'h200, 0);
        chk(q, 32'h0);
        @(posedge pclk) regress <= 1'b1;
        @(posedge pclk) regress <= 1'b0;
        xfer(0, 12'h220, 0);
        chk(q & 32'h2, 32'h0);
        xfer(1, 12'h000, 32'h0000_0100);
        xfer(0, 12'h004, 0);
        chk(q & 32'h2, 32'h2);
        @(posedge pclk) breach <= 1'b1;
        @(posedge pclk) breach <= 1'b0;
        xfer(0, 12'h004, 0);
        chk(q & 32'h2, 32'h0);
        // Only a reset unlocks the boot key, so the tamper clear needs a fresh one.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) xfer(1, 12'h200 + 12'(4 * i), nxt());
        xfer(0, 12'h220, 0);
        chk(q & 32'h6, 32'h2);
        @(posedge pclk) tamper <= 1'b1;
        @(posedge pclk) tamper <= 1'b0;
        xfer(0, 12'h220, 0);
        chk(q & 32'h6, 32'h4);
        conclude();
    end
endmodule : block_cipher_dual_engine_tb_top
`default_nettype wire
